// file: logic/fcc_control.sv
// control-command interpreter: read id, positioning, sense and interrupt cause
`timescale 1ns/1ns
module fcc_control #(
  parameter int NDRV = fcc_pkg::NUM_DRIVES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // command port
  input wire logic cmd_valid_i,
  input wire fcc_pkg::fcc_req_t cmd_i,
  output logic cmd_busy_o,
  output logic result_valid_o,
  output logic [7:0] status_zero_o,
  output logic [7:0] status_one_o,
  output logic [7:0] status_three_o,
  output logic [7:0] result_cylinder_o,
  output fcc_pkg::fcc_id_t read_id_o,
  input wire logic result_read_i,
  // configuration
  input wire logic [3:0] step_interval_code_i,
  input wire logic drive_polling_disable_i,
  input wire logic low_power_i,
  input wire logic transfer_result_i,
  // disk read side
  input wire logic index_pulse_n_i,
  input wire logic id_found_i,
  input wire fcc_pkg::fcc_id_t id_field_i,
  // format preamble
  input wire logic fmt_start_i,
  input wire logic [1:0] fmt_field_i,
  input wire logic fmt_byte_ready_i,
  output logic fmt_byte_valid_o,
  output logic [7:0] fmt_byte_o,
  output logic fmt_done_o,
  // drives
  input wire logic [NDRV-1:0] track_zero_sense_n_i,
  input wire logic [NDRV-1:0] drive_ready_i,
  input wire logic [NDRV-1:0] write_protect_i,
  output logic [NDRV-1:0] step_o,
  output logic [NDRV-1:0] step_direction_o,
  output logic [NDRV-1:0] drive_busy_o,
  // interrupt
  output logic interrupt_o
);
  typedef enum logic [1:0] {CS_IDLE, CS_READ_ID, CS_RESULT} fcc_ctl_st_t;
  fcc_ctl_st_t state_ff;
  logic [NDRV-1:0] start;
  logic [NDRV-1:0] step_busy;
  logic [NDRV-1:0] step_done;
  logic [NDRV-1:0] step_ec;
  logic [7:0] present_cylinder_count [NDRV];
  logic [NDRV-1:0] pending_ff;
  logic [NDRV-1:0] pend_ec_ff;
  logic [NDRV-1:0] unsensed_ff;
  logic poll_ff;
  logic low_power_ff;
  logic clear_pcn;
  logic [1:0] index_cnt_ff;
  logic index_prev_ff;
  logic [1:0] rid_drive_ff;
  logic sense_hit;
  logic [1:0] sense_drv;

  function automatic logic [7:0] st0(input logic [1:0] ic, input logic se, input logic ec, input logic [1:0] d);
    logic [7:0] v;
    v = {6'h00, d};
    v[fcc_pkg::ST0_IC_HI -: 2] = ic;
    v[fcc_pkg::ST0_SE_BIT] = se;
    v[fcc_pkg::ST0_EC_BIT] = ec;
    v[fcc_pkg::ST0_HD_BIT] = 1'b0;
    st0 = v;
  endfunction

  assign clear_pcn = low_power_ff && !low_power_i;

  genvar g;
  generate
    for (g = 0; g < NDRV; g++) begin : g_drv
      assign start[g] = cmd_valid_i && state_ff == CS_IDLE && cmd_i.drive == 2'(g) && !step_busy[g]
                        && (cmd_i.cmd == fcc_pkg::CMD_SEEK || cmd_i.cmd == fcc_pkg::CMD_RECAL
                            || cmd_i.cmd == fcc_pkg::CMD_REL_SEEK);
      fcc_stepper u_step (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .start_i(start[g]),
        .cmd_i(cmd_i.cmd),
        .target_i(cmd_i.target),
        .rel_dir_i(cmd_i.rel_dir),
        .step_interval_code_i(step_interval_code_i),
        .clear_pcn_i(clear_pcn),
        .track_zero_sense_n_i(track_zero_sense_n_i[g]),
        .step_o(step_o[g]),
        .step_direction_o(step_direction_o[g]),
        .busy_o(step_busy[g]),
        .done_o(step_done[g]),
        .ec_o(step_ec[g]),
        .present_cylinder_count_o(present_cylinder_count[g])
      );
    end
  endgenerate

  fcc_fm_gap u_gap (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .start_i(fmt_start_i),
    .field_i(fmt_field_i),
    .byte_ready_i(fmt_byte_ready_i),
    .byte_valid_o(fmt_byte_valid_o),
    .byte_o(fmt_byte_o),
    .done_o(fmt_done_o)
  );

  // lowest pending drive is reported first
  always_comb begin
    sense_hit = 1'b0;
    sense_drv = 2'h0;
    for (int i = NDRV - 1; i >= 0; i--) begin
      if (pending_ff[i]) begin
        sense_hit = 1'b1;
        sense_drv = 2'(i);
      end
    end
  end

  wire sense_cmd = cmd_valid_i && state_ff == CS_IDLE && cmd_i.cmd == fcc_pkg::CMD_SENSE_INT;

  // positioning completion flags; set beats clear
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pending_ff <= '0;
      pend_ec_ff <= '0;
      unsensed_ff <= '0;
    end else begin
      for (int i = 0; i < NDRV; i++) begin
        if (step_done[i]) begin
          pending_ff[i] <= 1'b1;
          pend_ec_ff[i] <= step_ec[i];
        end else if (clear_pcn) begin
          pending_ff[i] <= 1'b0;
          unsensed_ff[i] <= 1'b0;
        end else if (sense_cmd && sense_hit && sense_drv == 2'(i)) begin
          pending_ff[i] <= 1'b0;
          unsensed_ff[i] <= 1'b0;
        end
        if (start[i]) begin
          unsensed_ff[i] <= 1'b1;
        end
      end
    end
  end

  assign drive_busy_o = step_busy | unsensed_ff;
  // busy only while read id runs or a result waits
  assign cmd_busy_o = state_ff != CS_IDLE;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_power_ff <= 1'b0;
    end else begin
      low_power_ff <= low_power_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      poll_ff <= 1'b1;
    end else if (drive_polling_disable_i || sense_cmd || clear_pcn) begin
      poll_ff <= 1'b0;
    end
  end

  // index pulse edges during read id
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      index_prev_ff <= 1'b1;
    end else begin
      index_prev_ff <= index_pulse_n_i;
    end
  end

  logic rid_irq_ff;
  logic xfer_irq_ff;

  // command sequencer and result registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= CS_IDLE;
      index_cnt_ff <= 2'h0;
      rid_drive_ff <= 2'h0;
      rid_irq_ff <= 1'b0;
      status_zero_o <= 8'h00;
      status_one_o <= 8'h00;
      status_three_o <= 8'h00;
      result_cylinder_o <= 8'h00;
      read_id_o <= '0;
    end else begin
      if (clear_pcn) begin
        status_zero_o <= 8'h00;
        status_one_o <= 8'h00;
        result_cylinder_o <= 8'h00;
      end
      unique case (state_ff)
        CS_IDLE: begin
          if (cmd_valid_i) begin
            unique case (cmd_i.cmd)
              fcc_pkg::CMD_READ_ID: begin
                state_ff <= CS_READ_ID;
                index_cnt_ff <= 2'h0;
                rid_drive_ff <= cmd_i.drive;
              end
              fcc_pkg::CMD_SENSE_INT: begin
                state_ff <= CS_RESULT;
                if (sense_hit) begin
                  status_zero_o <= st0(pend_ec_ff[sense_drv] ? fcc_pkg::IC_ABNORMAL : fcc_pkg::IC_NORMAL,
                                       1'b1, pend_ec_ff[sense_drv], sense_drv);
                  result_cylinder_o <= present_cylinder_count[sense_drv];
                end else begin
                  status_zero_o <= st0(poll_ff ? fcc_pkg::IC_POLL : fcc_pkg::IC_ABNORMAL, 1'b0, 1'b0, 2'h0);
                  result_cylinder_o <= 8'h00;
                end
              end
              fcc_pkg::CMD_SENSE_DRV: begin
                // straight to result with drive status
                state_ff <= CS_RESULT;
                status_three_o <= {1'b0, write_protect_i[cmd_i.drive], drive_ready_i[cmd_i.drive],
                                   track_zero_sense_n_i[cmd_i.drive], 2'b00, cmd_i.drive};
              end
              default: state_ff <= CS_IDLE;
            endcase
          end
        end
        CS_READ_ID: begin
          if (id_found_i) begin
            read_id_o <= id_field_i;
            status_zero_o <= st0(fcc_pkg::IC_NORMAL, 1'b0, 1'b0, rid_drive_ff);
            status_one_o <= 8'h00;
            rid_irq_ff <= 1'b1;
            state_ff <= CS_RESULT;
          end else if (index_prev_ff && !index_pulse_n_i) begin
            if (index_cnt_ff == fcc_pkg::INDEX_LIMIT - 2'h1) begin
              status_zero_o <= st0(fcc_pkg::IC_ABNORMAL, 1'b0, 1'b0, rid_drive_ff);
              status_one_o <= 8'h01;
              rid_irq_ff <= 1'b1;
              state_ff <= CS_RESULT;
            end
            index_cnt_ff <= index_cnt_ff + 2'h1;
          end
        end
        CS_RESULT: begin
          if (result_read_i) begin
            rid_irq_ff <= 1'b0;
            state_ff <= CS_IDLE;
          end
        end
        default: state_ff <= CS_IDLE;
      endcase
    end
  end

  // transfer commands' result-phase interrupt, cleared on result read
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      xfer_irq_ff <= 1'b0;
    end else if (transfer_result_i) begin
      xfer_irq_ff <= 1'b1;
    end else if (result_read_i) begin
      xfer_irq_ff <= 1'b0;
    end
  end

  assign result_valid_o = state_ff == CS_RESULT;
  // level until sensed or read; read id, positioning, polling and transfer results
  assign interrupt_o = |pending_ff || poll_ff || rid_irq_ff || xfer_irq_ff;
endmodule

// file: logic/fcc_fm_gap.sv
// single-density format preamble: gap and sync byte sequencer
`timescale 1ns/1ns
module fcc_fm_gap (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  input wire logic [1:0] field_i,
  input wire logic byte_ready_i,
  // byte out
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic done_o
);
  logic [7:0] gap_left_ff;
  logic [7:0] sync_left_ff;
  logic active_ff;

  function automatic logic [7:0] gap_len(input logic [1:0] f);
    unique case (f)
      2'h0: gap_len = fcc_pkg::FM_GAP4A_LEN;
      2'h1: gap_len = fcc_pkg::FM_GAP1_LEN;
      default: gap_len = fcc_pkg::FM_GAP2_LEN;
    endcase
  endfunction

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_left_ff <= 8'h00;
      sync_left_ff <= 8'h00;
      active_ff <= 1'b0;
      byte_o <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!active_ff && start_i) begin
        active_ff <= 1'b1;
        gap_left_ff <= gap_len(field_i);
        sync_left_ff <= fcc_pkg::FM_SYNC_LEN;
        byte_o <= fcc_pkg::FM_GAP_BYTE;
      end else if (active_ff && byte_ready_i) begin
        if (gap_left_ff > 8'h01) begin
          gap_left_ff <= gap_left_ff - 8'h01;
        end else if (gap_left_ff == 8'h01) begin
          gap_left_ff <= 8'h00;
          byte_o <= fcc_pkg::FM_SYNC_BYTE;
        end else if (sync_left_ff > 8'h01) begin
          sync_left_ff <= sync_left_ff - 8'h01;
        end else begin
          active_ff <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

  assign byte_valid_o = active_ff;
endmodule

// file: logic/fcc_pkg.sv
// package: shared constants and types for the floppy control-command block
package fcc_pkg;
  // single-density format gap lengths (bytes of ff), sync length (bytes of 00) and the two byte values
  localparam logic [7:0] FM_GAP4A_LEN = 8'h28;
  localparam logic [7:0] FM_GAP1_LEN = 8'h1a;
  localparam logic [7:0] FM_GAP2_LEN = 8'h0b;
  localparam logic [7:0] FM_SYNC_LEN = 8'h06;
  localparam logic [7:0] FM_GAP_BYTE = 8'hff;
  localparam logic [7:0] FM_SYNC_BYTE = 8'h00;
  // recalibrate step limit
  localparam logic [7:0] RECAL_MAX_STEPS = 8'hff;
  // step pulse width and step interval unit in cycles (50 mhz)
  localparam int CLK_MHZ = 50;
  localparam int STEP_PULSE_US = 1;
  localparam int STEP_PULSE_CYC = STEP_PULSE_US * CLK_MHZ;
  localparam int STEP_UNIT_US = 500;
  localparam int STEP_UNIT_CYC = STEP_UNIT_US * CLK_MHZ;
  // status zero field positions and codes, read id index limit and drive count
  localparam int ST0_IC_HI = 7;
  localparam int ST0_SE_BIT = 5;
  localparam int ST0_EC_BIT = 4;
  localparam int ST0_HD_BIT = 2;
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_POLL = 2'h3;
  localparam logic [1:0] INDEX_LIMIT = 2'h2;
  localparam int NUM_DRIVES = 4;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_READ_ID, CMD_RECAL, CMD_SEEK, CMD_REL_SEEK, CMD_SENSE_INT, CMD_SENSE_DRV
  } fcc_cmd_t;

  typedef struct packed {
    fcc_cmd_t cmd;
    logic [1:0] drive;
    logic [7:0] target;
    logic rel_dir;
  } fcc_req_t;

  typedef struct packed {
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sec;
    logic [7:0] size;
  } fcc_id_t;
endpackage

// file: logic/fcc_stepper.sv
// one drive's head positioner: seek, relative seek and recalibrate stepping
`timescale 1ns/1ns
module fcc_stepper (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // command
  input wire logic start_i,
  input wire fcc_pkg::fcc_cmd_t cmd_i,
  input wire logic [7:0] target_i,
  input wire logic rel_dir_i,
  input wire logic [3:0] step_interval_code_i,
  input wire logic clear_pcn_i,
  // drive
  input wire logic track_zero_sense_n_i,
  output logic step_o,
  output logic step_direction_o,
  // status
  output logic busy_o,
  output logic done_o,
  output logic ec_o,
  output logic [7:0] present_cylinder_count_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_WAIT} fcc_step_st_t;
  fcc_step_st_t state_ff;
  fcc_pkg::fcc_cmd_t cmd_ff;
  logic [7:0] target_ff;
  logic [7:0] count_ff;
  logic [23:0] timer_ff;

  function automatic logic [23:0] interval_cyc(input logic [3:0] code);
    interval_cyc = 24'((16 - int'(code)) * fcc_pkg::STEP_UNIT_CYC);
  endfunction

  // need another step pulse?
  logic more;
  always_comb begin
    unique case (cmd_ff)
      fcc_pkg::CMD_RECAL: more = track_zero_sense_n_i == 1'b0 && count_ff != fcc_pkg::RECAL_MAX_STEPS;
      fcc_pkg::CMD_REL_SEEK: more = count_ff != target_ff;
      default: more = present_cylinder_count_o != target_ff;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cmd_ff <= fcc_pkg::CMD_NONE;
      target_ff <= 8'h00;
      count_ff <= 8'h00;
      timer_ff <= 24'h000000;
      step_o <= 1'b0;
      step_direction_o <= 1'b0;
      done_o <= 1'b0;
      ec_o <= 1'b0;
      present_cylinder_count_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      if (clear_pcn_i) begin
        present_cylinder_count_o <= 8'h00;
      end
      unique case (state_ff)
        ST_IDLE: begin
          if (start_i) begin
            cmd_ff <= cmd_i;
            target_ff <= target_i;
            count_ff <= 8'h00;
            ec_o <= 1'b0;
            state_ff <= ST_WAIT;
            timer_ff <= 24'h000001;
            if (cmd_i == fcc_pkg::CMD_RECAL) begin
              present_cylinder_count_o <= 8'h00;
              step_direction_o <= 1'b0;
            end else if (cmd_i == fcc_pkg::CMD_REL_SEEK) begin
              step_direction_o <= rel_dir_i;
            end else begin
              step_direction_o <= present_cylinder_count_o < target_i;
            end
          end
        end
        ST_PULSE: begin
          if (timer_ff == 24'h000000) begin
            step_o <= 1'b0;
            timer_ff <= interval_cyc(step_interval_code_i);
            state_ff <= ST_WAIT;
          end else begin
            timer_ff <= timer_ff - 24'h000001;
          end
        end
        ST_WAIT: begin
          if (timer_ff != 24'h000000) begin
            timer_ff <= timer_ff - 24'h000001;
          end else if (cmd_ff == fcc_pkg::CMD_REL_SEEK && more && !step_direction_o
                       && present_cylinder_count_o == 8'h00) begin
            ec_o <= 1'b1;
            done_o <= 1'b1;
            state_ff <= ST_IDLE;
          end else if (more) begin
            step_o <= 1'b1;
            count_ff <= count_ff + 8'h01;
            // one short: the load edge is itself a high cycle
            timer_ff <= 24'(fcc_pkg::STEP_PULSE_CYC - 1);
            state_ff <= ST_PULSE;
            if (cmd_ff != fcc_pkg::CMD_RECAL) begin
              present_cylinder_count_o <= step_direction_o ? present_cylinder_count_o + 8'h01
                                                           : present_cylinder_count_o - 8'h01;
            end
          end else begin
            ec_o <= cmd_ff == fcc_pkg::CMD_RECAL && track_zero_sense_n_i == 1'b0;
            done_o <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign busy_o = state_ff != ST_IDLE;
endmodule

// file: verif/fcc_control_assertions.sv
// checker: port timing relations of the control-command block
`timescale 1ns/1ns
module fcc_control_chk #(
  parameter int NDRV = 4
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // command and result
  input wire logic cmd_valid_i,
  input wire fcc_pkg::fcc_req_t cmd_i,
  input wire logic cmd_busy_o,
  input wire logic result_valid_o,
  input wire logic [7:0] status_zero_o,
  input wire logic [7:0] status_three_o,
  input wire logic result_read_i,
  input wire logic low_power_i,
  // drives and interrupt
  input wire logic [NDRV-1:0] step_o,
  input wire logic [NDRV-1:0] step_direction_o,
  input wire logic interrupt_o
);
  logic taken;
  logic [7:0] hi_cnt_ff;
  assign taken = cmd_valid_i && !cmd_busy_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // high run of drive 0 step
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) hi_cnt_ff <= 8'h00;
    else if (step_o[0]) hi_cnt_ff <= hi_cnt_ff + 8'h01;
    else hi_cnt_ff <= 8'h00;
  end
  chk_step_width: assert property (
    $fell(step_o[0]) |-> int'(hi_cnt_ff) == fcc_pkg::STEP_PULSE_CYC) else $error("step pulse width wrong");
  chk_dir_hold: assert property (
    step_o[1] |=> !step_o[1] || $stable(step_direction_o[1])) else $error("direction moved in pulse");
  chk_sense_res: assert property (
    taken && cmd_i.cmd == fcc_pkg::CMD_SENSE_INT |=> result_valid_o && !status_zero_o[2])
    else $error("sense result late or head bit set");
  chk_drv_res: assert property (
    taken && cmd_i.cmd == fcc_pkg::CMD_SENSE_DRV |=> result_valid_o && status_three_o[1:0] == $past(cmd_i.drive))
    else $error("drive status result wrong");
  chk_drv_noint: assert property (
    taken && cmd_i.cmd == fcc_pkg::CMD_SENSE_DRV && !interrupt_o |=> !interrupt_o) else $error("drive status raised irq");
  chk_exec_idle: assert property (
    taken && (cmd_i.cmd == fcc_pkg::CMD_SEEK || cmd_i.cmd == fcc_pkg::CMD_RECAL) |-> ##2 !cmd_busy_o)
    else $error("busy during positioning");
  chk_busy_result: assert property (
    result_valid_o && !result_read_i |=> result_valid_o && cmd_busy_o) else $error("result dropped before read");
  chk_code_se: assert property (
    result_valid_o && status_zero_o[5] |-> status_zero_o[7:6] != fcc_pkg::IC_POLL) else $error("bad code layout");
  chk_int_fall: assert property (
    $fell(interrupt_o) |-> $past(taken && cmd_i.cmd == fcc_pkg::CMD_SENSE_INT || result_read_i) || $past(low_power_i, 2))
    else $error("interrupt dropped unserviced");
endmodule
bind fcc_control fcc_control_chk #(.NDRV(NDRV)) fcc_control_chk_inst (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
  .cmd_busy_o(cmd_busy_o), .result_valid_o(result_valid_o), .status_zero_o(status_zero_o),
  .status_three_o(status_three_o), .result_read_i(result_read_i), .low_power_i(low_power_i),
  .step_o(step_o), .step_direction_o(step_direction_o), .interrupt_o(interrupt_o));

// file: verif/fcc_control_bench.sv
// testbench: control-command block against the drive model
`timescale 1ns/1ns
module fcc_control_bench;
  logic clk, rst, cmd_valid, busy, rv, rread, tres, idx_n, idx_en, idf;
  logic fst, fready, fvalid, fdone, intr, lowp;
  logic [1:0] ffield;
  logic [7:0] sz, s1, s3, rcyl, fbyte;
  logic [3:0] tz_n, step, dir, dbusy;
  fcc_pkg::fcc_req_t cmd;
  fcc_pkg::fcc_id_t rid, idfield;
  int n_fail = 0;
  int total_checks = 0;
  fcc_control fcc_control_inst (
    .core_clk_i(clk), .rst_i(rst), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_busy_o(busy),
    .result_valid_o(rv), .status_zero_o(sz), .status_one_o(s1), .status_three_o(s3),
    .result_cylinder_o(rcyl), .read_id_o(rid), .result_read_i(rread), .step_interval_code_i(4'hf),
    .drive_polling_disable_i(1'b0), .low_power_i(lowp), .transfer_result_i(tres),
    .index_pulse_n_i(idx_n), .id_found_i(idf), .id_field_i(idfield), .fmt_start_i(fst),
    .fmt_field_i(ffield), .fmt_byte_ready_i(fready), .fmt_byte_valid_o(fvalid), .fmt_byte_o(fbyte),
    .fmt_done_o(fdone), .track_zero_sense_n_i(tz_n), .drive_ready_i(4'h4), .write_protect_i(4'h4),
    .step_o(step), .step_direction_o(dir), .drive_busy_o(dbusy), .interrupt_o(intr));
  fcc_drive_model fcc_drive_model_inst (
    .core_clk_i(clk), .step_i(step), .step_direction_i(dir), .index_en_i(idx_en),
    .track_zero_sense_n_o(tz_n), .index_pulse_n_o(idx_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic issue(input fcc_pkg::fcc_cmd_t c, input logic [1:0] d, input logic [7:0] t, input logic r);
    @(negedge clk);
    while (busy !== 1'b0) @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{c, d, t, r};
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic consume();
    rread = 1'b1;
    @(negedge clk);
    rread = 1'b0;
  endtask
  // k: 0 interrupt, 1 result, 2+ step of drive k-2
  task automatic wait_on(input int k, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      if ((k == 0 ? intr : k == 1 ? rv : step[k-2]) === 1'b1) break;
      @(negedge clk);
    end
    check("wait bound", i < n, 1'b1);
  endtask
  task automatic sense(input logic [1:0] d, input logic [7:0] m, input logic [7:0] e, input logic [7:0] cyl);
    issue(fcc_pkg::CMD_SENSE_INT, d, 8'h00, 1'b0);
    check("sense valid", rv, 1'b1);
    check("status zero", sz & m, e);
    check("cylinder", rcyl, cyl);
    check("irq cleared", intr, 1'b0);
    consume();
  endtask
  task automatic t_poll();
    check("poll irq", intr, 1'b1);
    sense(2'h0, 8'he4, 8'hc0, 8'h00);
  endtask
  task automatic t_sdrv();
    issue(fcc_pkg::CMD_SENSE_DRV, 2'h2, 8'h00, 1'b0);
    check("drive status", s3 & 8'h73, 8'h72);
    check("no irq", intr, 1'b0);
    consume();
  endtask
  task automatic t_recal();
    issue(fcc_pkg::CMD_RECAL, 2'h0, 8'h00, 1'b0);
    check("exec idle", busy, 1'b0);
    wait_on(2, 200);
    check("recal dir", dir[0], 1'b0);
    wait_on(0, 40000);
    check("drive held", dbusy[0], 1'b1);
    sense(2'h0, 8'hff, 8'h20, 8'h00);
    check("drive freed", dbusy[0], 1'b0);
  endtask
  task automatic t_seek();
    issue(fcc_pkg::CMD_SEEK, 2'h1, 8'h01, 1'b0);
    wait_on(3, 200);
    check("seek dir", dir[1], 1'b1);
    wait_on(0, 40000);
    sense(2'h1, 8'hff, 8'h21, 8'h01);
  endtask
  task automatic t_rel();
    issue(fcc_pkg::CMD_REL_SEEK, 2'h2, 8'h01, 1'b0);
    wait_on(0, 40000);
    sense(2'h2, 8'h13, 8'h12, 8'h00);
  endtask
  task automatic t_lowp();
    check("irq serviced", intr, 1'b0);
    lowp = 1'b1;
    repeat (3) @(negedge clk);
    lowp = 1'b0;
    repeat (2) @(negedge clk);
    // count cleared: outward relative step from zero ends at once
    issue(fcc_pkg::CMD_REL_SEEK, 2'h1, 8'h01, 1'b0);
    wait_on(0, 200);
    sense(2'h1, 8'hff, 8'h71, 8'h00);
  endtask
  task automatic t_rid();
    issue(fcc_pkg::CMD_READ_ID, 2'h0, 8'h00, 1'b0);
    repeat (5) @(negedge clk);
    idf = 1'b1;
    idfield = 32'h0a0b0c0d;
    @(negedge clk);
    idf = 1'b0;
    wait_on(1, 10);
    check("read id", rid, 32'h0a0b0c0d);
    check("rid irq", intr, 1'b1);
    consume();
    check("read clears", intr, 1'b0);
    tres = 1'b1;
    @(negedge clk);
    tres = 1'b0;
    check("xfer irq", intr, 1'b1);
    consume();
    issue(fcc_pkg::CMD_READ_ID, 2'h0, 8'h00, 1'b0);
    idx_en = 1'b1;
    wait_on(1, 1500);
    idx_en = 1'b0;
    check("abnormal", sz[7:6], fcc_pkg::IC_ABNORMAL);
    check("missing mark", s1[0], 1'b1);
    consume();
  endtask
  task automatic t_fmt();
    logic [7:0] lens [3];
    int ff, zz, c;
    // gap length is the host's pick; preamble runs are fixed
    lens = '{8'h28, 8'h1a, 8'h0b};
    for (int f = 0; f < 3; f++) begin
      ff = 0;
      zz = 0;
      c = 0;
      ffield = 2'(f);
      fst = 1'b1;
      @(negedge clk);
      fst = 1'b0;
      repeat (300) begin
        if (fvalid === 1'b1 && fready === 1'b1 && fbyte === 8'hff) ff++;
        if (fvalid === 1'b1 && fready === 1'b1 && fbyte === 8'h00) zz++;
        if (fdone === 1'b1) break;
        @(negedge clk);
        c++;
        // stall now and then; no byte may be lost
        fready = (c % 7 != 3);
      end
      fready = 1'b1;
      check("gap bytes", ff, lens[f]);
      check("sync bytes", zz, 6);
    end
  endtask
  initial begin
    #(20 * 95000);
    n_fail++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    {cmd_valid, rread, tres, idx_en, idf, fst} = 6'h00;
    lowp = 1'b0;
    fready = 1'b1;
    ffield = 2'h0;
    cmd = '0;
    idfield = '0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_poll();
    t_sdrv();
    t_recal();
    // seek, relative seek, low power, read id, then format
    t_seek();
    t_rel();
    t_lowp();
    t_rid();
    t_fmt();
    give_verdict();
  end
endmodule

// file: verif/fcc_drive_model.sv
// drive mechanism model: head position, track zero sense, index pulses
`timescale 1ns/1ns
module fcc_drive_model #(
  parameter int NDRV = 4,
  parameter int IDX_PERIOD = 400
) (
  // clock
  input wire logic core_clk_i,
  // from controller
  input wire logic [NDRV-1:0] step_i,
  input wire logic [NDRV-1:0] step_direction_i,
  input wire logic index_en_i,
  // to controller
  output logic [NDRV-1:0] track_zero_sense_n_o,
  output logic index_pulse_n_o
);
  int track [NDRV];
  logic [NDRV-1:0] step_q;
  int idx_cnt;
  // drive 0 starts one track in so recalibrate has to step
  initial begin
    for (int i = 0; i < NDRV; i++) begin
      track[i] = (i == 0) ? 1 : 0;
    end
    step_q = '0;
    idx_cnt = 0;
    track_zero_sense_n_o = {{(NDRV-1){1'b1}}, 1'b0};
  end
  always @(posedge core_clk_i) begin
    step_q <= step_i;
    for (int i = 0; i < NDRV; i++) begin
      if (step_i[i] && !step_q[i]) begin
        if (step_direction_i[i]) track[i] = track[i] + 1;
        else if (track[i] > 0) track[i] = track[i] - 1;
      end
      track_zero_sense_n_o[i] <= (track[i] == 0);
    end
    idx_cnt <= index_en_i ? (idx_cnt + 1) % IDX_PERIOD : 0;
  end
  // index line idles high when the spindle is not watched
  assign index_pulse_n_o = !(index_en_i && idx_cnt > 10 && idx_cnt < 15);
endmodule
